// File: pkg/uerr_defines.svh
`ifndef UERR_DEFINES_SVH
`define UERR_DEFINES_SVH

// register offsets on the plain register port
`define UERR_OFF_EIE      8'h00
`define UERR_OFF_CNFG     8'h04
`define UERR_OFF_IE       8'h08
`define UERR_OFF_EIR      8'h0c
`define UERR_OFF_STAT     8'h10
`define UERR_OFF_MASK     8'h14
`define UERR_OFF_CTRL     8'h18

// error enable / flag bit positions
`define UERR_BIT_BITSTUFF 7
`define UERR_BIT_BUSMTX   6
`define UERR_BIT_DMA      5
`define UERR_BIT_TURNTO   4
`define UERR_BIT_FIELD    3
`define UERR_BIT_DATACRC  2
`define UERR_BIT_TOKEOF   1
`define UERR_BIT_PID      0

// configuration bit positions and writable mask
`define UERR_CFG_EYE      7
`define UERR_CFG_SIDL     4
`define UERR_CFG_LOWSPD   3
`define UERR_CFG_ASUSP    0
`define UERR_CFG_MASK     8'h99

// module interrupt enable: master error enable bit
`define UERR_IE_MASTER    1

// control register: software suspend bit
`define UERR_CTRL_SUSP    0

// reset values
`define UERR_RST_BYTE     8'h00

// event bits of the sticky status register
`define UERR_EV_ERR       0
`define UERR_EV_IRQ       1

`endif

// File: pkg/uerr_pkg.sv
package uerr_pkg;
	typedef logic [7:0] uerr_byte_t;

	// run state of the module
	typedef enum logic [1:0] {
		UERR_RUN     = 2'b00,
		UERR_IDLE    = 2'b01,
		UERR_SUSPEND = 2'b10
	} uerr_run_t;
endpackage : uerr_pkg

// File: logic/uerr_flag_bit.sv
`timescale 1ns/1ps
`include "uerr_defines.svh"

// one sticky error flag: detector sets, software clear by write-one
module uerr_flag_bit (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// set and clear
	input  wire logic set_i,
	input  wire logic clr_i,
	// flag
	output logic      flag_o
);
	typedef struct packed {
		logic flag;
	} uerr_flag_st_t;

	uerr_flag_st_t st;
	uerr_flag_st_t next_st;

	// set wins over a clear in the same cycle
	always_comb begin
		next_st = st;
		if (clr_i) begin
			next_st.flag = 1'b0;
		end
		if (set_i) begin
			next_st.flag = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flag_o = st.flag;

	set_wins_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		set_i |=> flag_o)
		else $error("flag lost a set");
endmodule : uerr_flag_bit

// File: logic/uerr_run_ctl.sv
`timescale 1ns/1ps
`include "uerr_defines.svh"

// run state from idle, sleep and suspend requests
module uerr_run_ctl
	import uerr_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// requests
	input  wire logic idle_i,
	input  wire logic sleep_i,
	input  wire logic halt_in_idle_i,
	input  wire logic auto_suspend_on_sleep_i,
	input  wire logic software_suspend_i,
	// state
	output logic      run_o,
	output logic      suspend_o
);
	typedef struct packed {
		uerr_run_t state;
	} uerr_run_st_t;

	uerr_run_st_t st;
	uerr_run_st_t next_st;
	logic         want_susp;

	// suspend from software bit, or from sleep only if enabled
	assign want_susp = software_suspend_i | (auto_suspend_on_sleep_i & sleep_i);

	always_comb begin
		next_st = st;
		case (st.state)
			UERR_RUN: begin
				if (want_susp) begin
					next_st.state = UERR_SUSPEND;
				end else if (idle_i && halt_in_idle_i) begin
					next_st.state = UERR_IDLE;
				end
			end
			UERR_IDLE: begin
				if (want_susp) begin
					next_st.state = UERR_SUSPEND;
				end else if (!(idle_i && halt_in_idle_i)) begin
					next_st.state = UERR_RUN;
				end
			end
			UERR_SUSPEND: begin
				if (!want_susp) begin
					next_st.state = UERR_RUN;
				end
			end
			default: begin
				next_st.state = UERR_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st <= '{state: UERR_RUN};
		end else begin
			st <= next_st;
		end
	end

	assign run_o     = (st.state == UERR_RUN);
	assign suspend_o = (st.state == UERR_SUSPEND);

	sleep_susp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(sleep_i && auto_suspend_on_sleep_i) |=> suspend_o)
		else $error("no auto suspend on sleep");
	no_auto_susp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(!software_suspend_i && !sleep_i) |=> !suspend_o)
		else $error("suspend without a cause");
	idle_halt_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(idle_i && !halt_in_idle_i && !want_susp) |=> run_o)
		else $error("halted in idle while allowed to run");
endmodule : uerr_run_ctl

// File: logic/uerr_top.sv
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "uerr_defines.svh"

module uerr_top
	import uerr_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	// error detectors, one-cycle pulses
	input  wire logic        bitstuff_err_i,
	input  wire logic        busmatrix_err_i,
	input  wire logic        dma_err_i,
	input  wire logic        turnaround_timeout_i,
	input  wire logic        field_size_err_i,
	input  wire logic        data_crc_fail_i,
	input  wire logic        token_crc_err_i,
	input  wire logic        end_of_frame_err_i,
	input  wire logic        packet_id_check_i,
	// mode and power
	input  wire logic        host_mode_i,
	input  wire logic        idle_i,
	input  wire logic        sleep_i,
	// outputs
	output logic             usb_module_irq_flag_o,
	output logic             eye_pattern_test_en_o,
	output logic             low_speed_only_en_o,
	output logic             module_run_o,
	output logic             module_suspend_o,
	output logic             irq_o
);
	typedef struct packed {
		uerr_byte_t eie;
		uerr_byte_t cnfg;
		uerr_byte_t ie;
		logic       sw_susp;
		logic [1:0] stat;
		logic [1:0] mask;
		logic [31:0] rdata;
	} uerr_st_t;

	uerr_st_t   st;
	uerr_st_t   next_st;
	uerr_byte_t err_set;
	uerr_byte_t err_flag;
	uerr_byte_t err_clr;
	uerr_byte_t err_gated;
	logic       err_any;
	logic       module_irq;
	logic [1:0] ev;

	// bit 1 detector depends on role
	always_comb begin
		err_set = '0;
		err_set[`UERR_BIT_BITSTUFF] = bitstuff_err_i;
		err_set[`UERR_BIT_BUSMTX]   = busmatrix_err_i;
		err_set[`UERR_BIT_DMA]      = dma_err_i;
		err_set[`UERR_BIT_TURNTO]   = turnaround_timeout_i;
		err_set[`UERR_BIT_FIELD]    = field_size_err_i;
		err_set[`UERR_BIT_DATACRC]  = data_crc_fail_i;
		err_set[`UERR_BIT_TOKEOF]   = host_mode_i ? end_of_frame_err_i : token_crc_err_i;
		err_set[`UERR_BIT_PID]      = packet_id_check_i;
	end

	// write-one-to-clear of the error flags
	assign err_clr = (wr_i && addr_i == `UERR_OFF_EIR) ? wdata_i[7:0] : '0;

	// flags set whatever the enables say
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			uerr_flag_bit u_flag (
				.clk_i  (clk_i),
				.rstn_i (rstn_i),
				.set_i  (err_set[gi]),
				.clr_i  (err_clr[gi]),
				.flag_o (err_flag[gi])
			);
		end
	endgenerate

	// per-bit enable gate
	assign err_gated  = err_flag & st.eie;
	assign err_any    = |err_gated;
	// master error enable
	assign module_irq = err_any & st.ie[`UERR_IE_MASTER];

	uerr_run_ctl u_run (
		.clk_i                   (clk_i),
		.rstn_i                  (rstn_i),
		.idle_i                  (idle_i),
		.sleep_i                 (sleep_i),
		.halt_in_idle_i          (st.cnfg[`UERR_CFG_SIDL]),
		.auto_suspend_on_sleep_i (st.cnfg[`UERR_CFG_ASUSP]),
		.software_suspend_i      (st.sw_susp),
		.run_o                   (module_run_o),
		.suspend_o               (module_suspend_o)
	);

	// sticky events: any error detected, module irq asserted
	assign ev[`UERR_EV_ERR] = |err_set;
	assign ev[`UERR_EV_IRQ] = module_irq;

	// register writes, read data, sticky status
	always_comb begin
		next_st       = st;
		next_st.rdata = '0;
		if (wr_i) begin
			case (addr_i)
				`UERR_OFF_EIE:  next_st.eie = wdata_i[7:0];
				// only implemented bits take a write
				`UERR_OFF_CNFG: next_st.cnfg = wdata_i[7:0] & `UERR_CFG_MASK;
				`UERR_OFF_IE:   next_st.ie = wdata_i[7:0];
				`UERR_OFF_MASK: next_st.mask = wdata_i[1:0];
				`UERR_OFF_CTRL: next_st.sw_susp = wdata_i[`UERR_CTRL_SUSP];
				default: begin
				end
			endcase
		end
		if (rd_i) begin
			case (addr_i)
				`UERR_OFF_EIE:  next_st.rdata = {24'h000000, st.eie};
				`UERR_OFF_CNFG: next_st.rdata = {24'h000000, st.cnfg};
				`UERR_OFF_IE:   next_st.rdata = {24'h000000, st.ie};
				`UERR_OFF_EIR:  next_st.rdata = {24'h000000, err_flag};
				`UERR_OFF_STAT: next_st.rdata = {30'h0, st.stat};
				`UERR_OFF_MASK: next_st.rdata = {30'h0, st.mask};
				`UERR_OFF_CTRL: next_st.rdata = {31'h0, st.sw_susp};
				default:        next_st.rdata = '0;
			endcase
		end
		// read clears status, a same-cycle event still lands
		if (rd_i && addr_i == `UERR_OFF_STAT) begin
			next_st.stat = '0;
		end
		next_st.stat = next_st.stat | ev;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_o               = st.rdata;
	assign usb_module_irq_flag_o = module_irq;
	assign eye_pattern_test_en_o = st.cnfg[`UERR_CFG_EYE];
	assign low_speed_only_en_o   = st.cnfg[`UERR_CFG_LOWSPD];
	assign irq_o                 = |(st.stat & st.mask);

	bitstuff_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_flag[7] && st.eie[7] && st.ie[1]) |-> usb_module_irq_flag_o)
		else $error("bit stuff error not raised");
	busmtx_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_flag == 8'h40 && !st.eie[6]) |-> !usb_module_irq_flag_o)
		else $error("bus matrix error not blocked");
	dma_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_flag == 8'h20) |-> (usb_module_irq_flag_o == (st.eie[5] & st.ie[1])))
		else $error("dma error gating wrong");
	turnto_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_flag == 8'h10) |-> (usb_module_irq_flag_o == (st.eie[4] & st.ie[1])))
		else $error("turnaround gating wrong");
	field_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_flag == 8'h08) |-> (usb_module_irq_flag_o == (st.eie[3] & st.ie[1])))
		else $error("field size gating wrong");
	crc16_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_flag == 8'h04) |-> (usb_module_irq_flag_o == (st.eie[2] & st.ie[1])))
		else $error("data crc gating wrong");
	token_crc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(token_crc_err_i && !host_mode_i) |=> err_flag[1])
		else $error("token crc not captured in device mode");
	eof_host_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(end_of_frame_err_i && host_mode_i) |=> err_flag[1])
		else $error("end of frame not captured in host mode");
	pid_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_flag == 8'h01) |-> (usb_module_irq_flag_o == (st.eie[0] & st.ie[1])))
		else $error("pid gating wrong");
	master_en_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!st.ie[1] |-> !usb_module_irq_flag_o)
		else $error("irq without master enable");
	cfg_rsvd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(rd_i && addr_i == `UERR_OFF_CNFG) |=> ((rdata_o & 32'hffffff66) == 32'h0))
		else $error("reserved config bits read nonzero");
	flag_always_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(dma_err_i && !st.eie[5]) |=> err_flag[5])
		else $error("disabled error flag not set");

	// detector pulse, then enable and master seen set in the flag's first cycle
	sequence s_bitstuff_on;
		bitstuff_err_i ##1 (st.eie[7] && st.ie[1]);
	endsequence
	sequence s_busmtx_on;
		busmatrix_err_i ##1 (st.eie[6] && st.ie[1]);
	endsequence
	sequence s_dma_on;
		dma_err_i ##1 (st.eie[5] && st.ie[1]);
	endsequence
	sequence s_turnto_on;
		turnaround_timeout_i ##1 (st.eie[4] && st.ie[1]);
	endsequence
	sequence s_field_on;
		field_size_err_i ##1 (st.eie[3] && st.ie[1]);
	endsequence
	sequence s_datacrc_on;
		data_crc_fail_i ##1 (st.eie[2] && st.ie[1]);
	endsequence
	// bit 1 source follows the role sampled together with the pulse
	sequence s_token_on;
		(token_crc_err_i && !host_mode_i) ##1 (st.eie[1] && st.ie[1]);
	endsequence
	sequence s_eof_on;
		(end_of_frame_err_i && host_mode_i) ##1 (st.eie[1] && st.ie[1]);
	endsequence
	sequence s_pid_on;
		packet_id_check_i ##1 (st.eie[0] && st.ie[1]);
	endsequence
	// a lone bit stuff flag whose enable is clear
	sequence s_bitstuff_off;
		bitstuff_err_i ##1 (err_flag == 8'h80 && !st.eie[7]);
	endsequence

	// set beats a same-cycle clear, so no write guard is needed on the pulse
	bitstuff_path_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_bitstuff_on |-> usb_module_irq_flag_o)
		else $error("bit stuff error did not reach the irq flag");
	busmtx_path_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_busmtx_on |-> usb_module_irq_flag_o)
		else $error("bus matrix error did not reach the irq flag");
	dma_path_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_dma_on |-> usb_module_irq_flag_o)
		else $error("dma error did not reach the irq flag");
	turnto_path_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_turnto_on |-> usb_module_irq_flag_o)
		else $error("turnaround error did not reach the irq flag");
	field_path_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_field_on |-> usb_module_irq_flag_o)
		else $error("field size error did not reach the irq flag");
	datacrc_path_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_datacrc_on |-> usb_module_irq_flag_o)
		else $error("data crc error did not reach the irq flag");
	token_path_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_token_on |-> usb_module_irq_flag_o)
		else $error("token crc error did not reach the irq flag");
	eof_path_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_eof_on |-> usb_module_irq_flag_o)
		else $error("end of frame error did not reach the irq flag");
	pid_path_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_pid_on |-> usb_module_irq_flag_o)
		else $error("pid error did not reach the irq flag");
	bitstuff_block_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_bitstuff_off |-> !usb_module_irq_flag_o)
		else $error("disabled bit stuff error raised the irq flag");

	// shared bit 1: gating and which source may set it; then master enable passing any gated flag
	bitone_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_flag == 8'h02) |-> (usb_module_irq_flag_o == (st.eie[1] & st.ie[1])))
		else $error("bit one gating wrong");
	host_bitone_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(host_mode_i && !end_of_frame_err_i && !err_flag[1]) |=> !err_flag[1])
		else $error("token crc set bit one in host mode");
	device_bitone_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(!host_mode_i && !token_crc_err_i && !err_flag[1]) |=> !err_flag[1])
		else $error("end of frame set bit one in device mode");
	master_pass_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(st.ie[1] && err_gated != 8'h00) |-> usb_module_irq_flag_o)
		else $error("enabled error blocked with master set");

	// flags follow detectors and write-one clears
	flags_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(err_set != 8'h00) |=> ((err_flag & $past(err_set)) == $past(err_set)))
		else $error("detected error left no flag");
	flag_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(wr_i && addr_i == `UERR_OFF_EIR && err_set == 8'h00)
		|=> ((err_flag & $past(wdata_i[7:0])) == 8'h00))
		else $error("write one did not clear a flag");

	// configuration outputs track the written bits
	eye_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(wr_i && addr_i == `UERR_OFF_CNFG) |=> (eye_pattern_test_en_o == $past(wdata_i[7])))
		else $error("eye pattern bit not taken");
	lsd_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(wr_i && addr_i == `UERR_OFF_CNFG) |=> (low_speed_only_en_o == $past(wdata_i[3])))
		else $error("low speed bit not taken");
	cfg_ignore_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(wr_i && addr_i == `UERR_OFF_CNFG) |=> ((st.cnfg & ~`UERR_CFG_MASK) == 8'h00))
		else $error("unimplemented config bit took a write");

	// run state seen from the register side
	idle_stop_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(idle_i && st.cnfg[4] && !st.sw_susp && !(sleep_i && st.cnfg[0]))
		|=> !module_run_o)
		else $error("module kept running in idle");
	sleep_ignore_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(sleep_i && !st.cnfg[0] && !st.sw_susp) |=> !module_suspend_o)
		else $error("sleep suspended without auto suspend");
	soft_susp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		st.sw_susp |=> module_suspend_o)
		else $error("software suspend ignored");

	// read data stands one cycle, zero otherwise
	rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!rd_i |=> (rdata_o == 32'h0))
		else $error("read data without a read");
	eie_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(rd_i && addr_i == `UERR_OFF_EIE) |=> (rdata_o == {24'h000000, $past(st.eie)}))
		else $error("enable register read wrong");
	ie_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(rd_i && addr_i == `UERR_OFF_IE) |=> (rdata_o == {24'h000000, $past(st.ie)}))
		else $error("module enable read wrong");
	flags_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(rd_i && addr_i == `UERR_OFF_EIR) |=> (rdata_o == {24'h000000, $past(err_flag)}))
		else $error("flag register read wrong");
	ctrl_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(rd_i && addr_i == `UERR_OFF_CTRL) |=> (rdata_o == {31'h0, $past(st.sw_susp)}))
		else $error("control register read wrong");

	// sticky status: read clears, a same-cycle event wins
	stat_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(rd_i && addr_i == `UERR_OFF_STAT && ev == 2'b00) |=> (st.stat == 2'b00))
		else $error("status not cleared by read");
	stat_wins_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(rd_i && addr_i == `UERR_OFF_STAT && ev != 2'b00) |=> (st.stat == $past(ev)))
		else $error("event lost to a status read");
	stat_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ev[0] |=> st.stat[0])
		else $error("error event not recorded");
endmodule : uerr_top

// File: testbench/uerr_det_model.sv
`timescale 1ns/1ps

// detector side: turns one bench request into a one-cycle error pulse
module uerr_det_model (
	// clock
	input  wire logic       clk_i,
	// request, one bit a detector
	input  wire logic [8:0] fire_i,
	// detector pulses
	output logic [8:0]      pulse_o
);
	// registered so a pulse never shares an edge with the bench request
	always_ff @(posedge clk_i) begin
		pulse_o <= fire_i;
	end
endmodule : uerr_det_model

// File: testbench/tb.sv
`timescale 1ns/1ps
`include "uerr_defines.svh"

module tb;
	logic        clk, rstn, wr, rd, host, idle, sleep;
	logic        irqf, eye, lsd, run, susp, irq;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [8:0]  fire, pulse;
	int          n_mismatch, comparisons, cyc, seed, eie, flags;
	// flag bit of each detector; last entry is end-of-frame in host mode
	int          bitpos [9] = '{7, 6, 5, 4, 3, 2, 1, 0, 1};

	uerr_det_model det (.clk_i(clk), .fire_i(fire), .pulse_o(pulse));
	uerr_top DUT (.clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .bitstuff_err_i(pulse[0]), .busmatrix_err_i(pulse[1]),
		.dma_err_i(pulse[2]), .turnaround_timeout_i(pulse[3]), .field_size_err_i(pulse[4]),
		.data_crc_fail_i(pulse[5]), .token_crc_err_i(pulse[6]), .end_of_frame_err_i(pulse[8]),
		.packet_id_check_i(pulse[7]), .host_mode_i(host), .idle_i(idle), .sleep_i(sleep),
		.usb_module_irq_flag_o(irqf), .eye_pattern_test_en_o(eye),
		.low_speed_only_en_o(lsd), .module_run_o(run), .module_suspend_o(susp),
		.irq_o(irq));

	initial clk = 1'b0;
	// 200 mhz clock
	always #2.5 clk = ~clk;

	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_w

	task automatic chk_b(input string nm, input logic e, input logic g);
		chk_w(nm, {31'h0, e}, {31'h0, g});
	endtask : chk_b

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	// read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_w(nm, e, rdata);
	endtask : rd_chk

	task automatic fire_err(input int k);
		@(posedge clk);
		fire <= 9'h1 << k;
		@(posedge clk);
		fire <= 9'h0;
		repeat (2) @(posedge clk);
		#1;
		flags = flags | (1 << bitpos[k]);
	endtask : fire_err

	// run state follows its registered request one edge later
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	initial begin
		{rstn, wr, rd, host, idle, sleep, addr, wdata, fire} = '0;
		{n_mismatch, comparisons, cyc, flags} = '0;
		seed = 27342;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(`UERR_OFF_EIE, 32'h0, "eie reset");
		rd_chk(`UERR_OFF_CNFG, 32'h0, "cnfg reset");
		rd_chk(`UERR_OFF_IE, 32'h0, "ie reset");
		chk_b("run reset", 1'b1, run);
		wr_reg(`UERR_OFF_CNFG, 32'hffffffff);
		rd_chk(`UERR_OFF_CNFG, 32'h99, "cnfg mask");
		chk_b("eye", 1'b1, eye);
		chk_b("low speed", 1'b1, lsd);
		wr_reg(`UERR_OFF_CNFG, 32'h0);
		chk_b("eye off", 1'b0, eye);
		chk_b("low speed off", 1'b0, lsd);
		wr_reg(8'h40, 32'hffffffff);
		rd_chk(8'h40, 32'h0, "unmapped");
		// every source with its enable set, then cleared, others random
		wr_reg(`UERR_OFF_IE, 32'h2);
		for (int k = 0; k < 9; k++) begin
			for (int p = 0; p < 2; p++) begin
				@(posedge clk);
				host <= (k == 8);
				eie = $random(seed) & 8'hff;
				eie = p ? (eie & ~(1 << bitpos[k])) : (eie | (1 << bitpos[k]));
				wr_reg(`UERR_OFF_EIE, eie);
				fire_err(k);
				chk_b("irq flag", (flags & eie) != 0, irqf);
				rd_chk(`UERR_OFF_EIR, flags, "flags");
				wr_reg(`UERR_OFF_EIR, flags);
				flags = 0;
				chk_b("irq flag clear", 1'b0, irqf);
			end
		end
		// bit 1 takes only the source of the current role
		fire_err(6);
		rd_chk(`UERR_OFF_EIR, 32'h0, "token crc in host");
		@(posedge clk);
		host <= 1'b0;
		fire_err(8);
		rd_chk(`UERR_OFF_EIR, 32'h0, "eof in device");
		flags = 0;
		// master enable gates the enabled bit stuff source
		wr_reg(`UERR_OFF_EIE, 32'hff);
		wr_reg(`UERR_OFF_IE, 32'h0);
		fire_err(0);
		chk_b("master off", 1'b0, irqf);
		wr_reg(`UERR_OFF_IE, 32'h2);
		chk_b("master on", 1'b1, irqf);
		wr_reg(`UERR_OFF_EIR, flags);
		flags = 0;
		// sticky status, mask and read clear
		rd_chk(`UERR_OFF_STAT, 32'h3, "stat events");
		rd_chk(`UERR_OFF_STAT, 32'h0, "stat cleared");
		wr_reg(`UERR_OFF_IE, 32'h0);
		fire_err(2);
		chk_b("irq masked", 1'b0, irq);
		wr_reg(`UERR_OFF_MASK, 32'h1);
		chk_b("irq unmasked", 1'b1, irq);
		rd_chk(`UERR_OFF_STAT, 32'h1, "stat error");
		chk_b("irq after read", 1'b0, irq);
		wr_reg(`UERR_OFF_EIR, flags);
		flags = 0;
		// idle halt, sleep suspend and software suspend
		@(posedge clk);
		idle <= 1'b1;
		wr_reg(`UERR_OFF_CNFG, 32'h10);
		settle();
		chk_b("halt in idle", 1'b0, run);
		wr_reg(`UERR_OFF_CNFG, 32'h0);
		settle();
		chk_b("run in idle", 1'b1, run);
		@(posedge clk);
		idle  <= 1'b0;
		sleep <= 1'b1;
		wr_reg(`UERR_OFF_CNFG, 32'h1);
		settle();
		chk_b("sleep suspend", 1'b1, susp);
		wr_reg(`UERR_OFF_CNFG, 32'h0);
		settle();
		chk_b("no auto suspend", 1'b0, susp);
		@(posedge clk);
		sleep <= 1'b0;
		wr_reg(`UERR_OFF_CTRL, 32'h1);
		settle();
		chk_b("soft suspend", 1'b1, susp);
		wr_reg(`UERR_OFF_CTRL, 32'h0);
		settle();
		chk_b("resume", 1'b0, susp);
		end_sim();
	end
endmodule : tb
